/* File: scr_interp.sv */
/*
 * Serial command interpreter: frames incoming host bytes, checks and
 * decodes commands, keeps ID base and receiver gain, and answers with
 * reply frames. Assumes byte-wide serial streams synchronous to
 * i_clock and an external nonvolatile store for the base and its
 * rewrite count.
 */
`timescale 1ns/1ps
`default_nettype none
`include "scr_defines.svh"
module scr_interp #(
  parameter logic [31:0] UNIQUE_ID = 32'h0123_4567, // Arbitrary value
  parameter logic [31:0] APP_VERSION = 32'h0100_0000, // Arbitrary value
  parameter logic [31:0] IF_VERSION = 32'h0100_0000, // Arbitrary value
  parameter int MAX_REWRITES = `SCR_MAX_REWRITES,
  parameter int REPLY_LIMIT = `SCR_REPLY_CYCLES
) (
  input wire logic i_clock, // System clock, 10 MHz
  input wire logic i_rst, // Async reset, high
  input wire logic [7:0] i_rx_data, // Byte from host
  input wire logic i_rx_valid, // Byte strobe from host
  output logic [7:0] o_tx_data, // Byte to host
  output logic o_tx_valid, // Byte to host offered
  input wire logic i_tx_ready, // Host link takes byte
  input wire logic [24:0] i_nvm_base, // Stored base, upper bits
  input wire logic [3:0] i_nvm_count, // Stored rewrite count
  output logic o_nvm_write, // Store new base pulse
  output logic [24:0] o_nvm_base, // Base to store
  output logic [3:0] o_nvm_count, // Count to store
  output logic [31:0] o_id_base, // Current ID range base
  output logic o_gain_high, // Receiver in high gain
  output logic o_ctrl_reset, // Controller reset pulse
  output logic o_radio_valid, // Radio frame to send
  output logic [7:0] o_radio_type, // Radio frame type
  output logic [31:0] o_radio_data, // Radio frame data
  output logic [31:0] o_radio_id, // Radio frame identifier
  output logic [7:0] o_radio_status, // Radio frame status
  output logic o_busy // Frame held, awaiting reply
);
  // ********************************
  // Parameter checks
  // ********************************
  generate
    if (MAX_REWRITES < 1 || MAX_REWRITES > 15) begin : g_bad_rewrites
      $error("MAX_REWRITES must fit the 4-bit count");
    end
    if (REPLY_LIMIT < 16) begin : g_bad_limit
      $error("REPLY_LIMIT too short for the decoder");
    end
  endgenerate

  // ********************************
  // Declarations
  // ********************************
  scr_reply_if rp ();

  scr_pkg::scr_rx_state_t rx_state;
  logic [3:0] rx_idx;
  logic [7:0] rx_sum;
  logic [7:0] rx_buf [0:11];
  logic [24:0] base_hi;
  logic [3:0] rewrites;
  logic loaded;
  logic [15:0] wait_cnt;
  logic timed_out;
  logic exec_done;

  logic [7:0] f_hdr;
  logic [7:0] f_type;
  logic [31:0] f_data;
  logic [31:0] f_id;
  logic [2:0] f_seq;
  logic [4:0] f_len;
  logic [31:0] base_full;

  logic reply_en;
  logic [7:0] reply_kind;
  logic [63:0] reply_payload;
  logic act_base;
  logic act_gain;
  logic gain_val;
  logic act_reset;
  logic act_radio;
  logic id_own;

  // ********************************
  // Frame field views
  // ********************************
  assign f_hdr = rx_buf[0];
  assign f_type = rx_buf[1];
  assign f_data = {rx_buf[2], rx_buf[3], rx_buf[4], rx_buf[5]};
  assign f_id = {rx_buf[6], rx_buf[7], rx_buf[8], rx_buf[9]};
  assign f_seq = f_hdr[7:5];
  assign f_len = f_hdr[4:0];
  assign base_full = {base_hi, 7'h00}; // Low seven bits always zero

  // ********************************
  // Receive framer
  // ********************************
  // Hunts for the two sync bytes, then collects twelve body bytes and
  // sums all but the last. Bytes arriving while a frame is being
  // executed are dropped: the host waits for each reply.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rx_state <= scr_pkg::RX_SYNC1;
      rx_idx <= 4'h0;
      rx_sum <= 8'h00;
    end else begin
      case (rx_state)
        scr_pkg::RX_SYNC1: begin
          if (i_rx_valid && i_rx_data == `SCR_SYNC1) begin
            rx_state <= scr_pkg::RX_SYNC0;
          end
        end
        scr_pkg::RX_SYNC0: begin
          if (i_rx_valid) begin
            if (i_rx_data == `SCR_SYNC0) begin
              rx_state <= scr_pkg::RX_BODY;
              rx_idx <= 4'h0;
              rx_sum <= 8'h00;
            end else if (i_rx_data != `SCR_SYNC1) begin
              rx_state <= scr_pkg::RX_SYNC1;
            end
          end
        end
        scr_pkg::RX_BODY: begin
          if (i_rx_valid) begin
            if (rx_idx == `SCR_BODY_LAST) begin
              rx_state <= scr_pkg::RX_EXEC;
            end else begin
              rx_idx <= rx_idx + 4'h1;
              rx_sum <= rx_sum + i_rx_data; // Sync and checksum skipped
            end
          end
        end
        scr_pkg::RX_EXEC: begin
          if (exec_done) begin
            rx_state <= scr_pkg::RX_SYNC1;
          end
        end
        default: begin
          rx_state <= scr_pkg::RX_SYNC1;
        end
      endcase
    end
  end

  // Body store; plain storage, so no reset is needed
  always_ff @(posedge i_clock) begin
    if (rx_state == scr_pkg::RX_BODY && i_rx_valid) begin
      rx_buf[rx_idx] <= i_rx_data;
    end
  end

  // ********************************
  // Own identifier check
  // ********************************
  // Zero selects the unique ID; otherwise the ID must be the unique one
  // or lie in the 128-wide range, never the broadcast value.
  assign id_own = (f_id != `SCR_BROADCAST) &&
                  (f_id == 32'h0 || f_id == UNIQUE_ID ||
                   f_id[31:7] == base_hi);

  // ********************************
  // Command decoder
  // ********************************
  // Syntax checks go checksum, length, sequence, then type; the first
  // failing field is the one reported.
  always_comb begin
    reply_en = 1'b1;
    reply_kind = `SCR_R_OK;
    reply_payload = 64'h0; // Don't-care bytes sent as zero
    act_base = 1'b0;
    act_gain = 1'b0;
    gain_val = o_gain_high;
    act_reset = 1'b0;
    act_radio = 1'b0;
    if (rx_sum != rx_buf[11]) begin
      reply_kind = `SCR_F_CHK;
    end else if (f_len != `SCR_LENGTH) begin
      reply_kind = `SCR_F_LEN;
    end else if (f_seq == `SCR_SEQ_RADIO) begin
      if (id_own) begin
        act_radio = 1'b1;
      end else begin
        reply_kind = `SCR_R_TX_ID; // Frame dropped
      end
    end else if (f_seq != `SCR_SEQ_CMD) begin
      reply_kind = `SCR_F_SEQ;
    end else begin
      case (f_type)
        `SCR_T_SET_BASE: begin
          if (rewrites >= 4'(MAX_REWRITES)) begin
            reply_kind = `SCR_R_FAIL;
          end else if (f_data < `SCR_BASE_MIN ||
                       f_data > `SCR_BASE_MAX) begin
            reply_kind = `SCR_R_RANGE;
          end else begin
            act_base = 1'b1; // Confirmed with OK
          end
        end
        `SCR_T_READ_BASE: begin
          reply_kind = `SCR_R_BASE; // MSB first
          reply_payload = {base_full, 32'h0};
        end
        `SCR_T_SET_GAIN: begin
          if (rx_buf[2] == `SCR_GAIN_LOW) begin
            act_gain = 1'b1;
            gain_val = 1'b0;
          end else if (rx_buf[2] == `SCR_GAIN_HIGH) begin
            act_gain = 1'b1;
            gain_val = 1'b1;
          end else begin
            reply_kind = `SCR_R_FAIL; // Unknown gain code
          end
        end
        `SCR_T_READ_GAIN: begin
          reply_kind = `SCR_R_GAIN;
          reply_payload = {7'h00, o_gain_high, 56'h0};
        end
        `SCR_T_RESET: begin
          reply_en = 1'b0; // No reply for reset
          act_reset = 1'b1;
        end
        `SCR_T_READ_VER: begin
          reply_kind = `SCR_R_VER;
          reply_payload = {APP_VERSION, IF_VERSION};
        end
        default: begin
          reply_kind = `SCR_F_TYPE;
        end
      endcase
    end
  end

  // ********************************
  // Execution handshake
  // ********************************
  // A frame finishes when its reply is handed over, or at once when no
  // reply is due. A reply that cannot start within the limit is
  // abandoned: the host has given up on it by then.
  assign timed_out = (32'(wait_cnt) >= 32'(REPLY_LIMIT - 1));
  assign exec_done = (rx_state == scr_pkg::RX_EXEC) &&
                     (!reply_en || !rp.busy || timed_out);
  assign rp.start = (rx_state == scr_pkg::RX_EXEC) && reply_en &&
                    !rp.busy;
  assign rp.hdr = `SCR_REPLY_HDR; // Reply sequence 0b100
  assign rp.kind = reply_kind;
  assign rp.payload = reply_payload;

  // Wait counter from frame end to reply start
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wait_cnt <= 16'h0;
    end else if (rx_state != scr_pkg::RX_EXEC || exec_done) begin
      wait_cnt <= 16'h0;
    end else if (!timed_out) begin
      wait_cnt <= wait_cnt + 16'h1;
    end
  end

  // ********************************
  // ID base and rewrite count
  // ********************************
  // The stored base is caught from the store on the first clock after
  // reset; the unique ID is a constant and has no write path.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      loaded <= 1'b0;
      base_hi <= 25'h0;
      rewrites <= 4'h0;
    end else if (!loaded) begin
      loaded <= 1'b1;
      base_hi <= i_nvm_base;
      rewrites <= i_nvm_count;
    end else if (exec_done && act_base) begin
      base_hi <= f_data[31:7]; // Only upper 25 bits kept
      rewrites <= rewrites + 4'h1;
    end
  end

  // Store request: one pulse per successful rewrite
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_nvm_write <= 1'b0;
      o_nvm_base <= 25'h0;
      o_nvm_count <= 4'h0;
    end else begin
      o_nvm_write <= exec_done && act_base && loaded;
      if (exec_done && act_base) begin
        o_nvm_base <= f_data[31:7];
        o_nvm_count <= rewrites + 4'h1;
      end
    end
  end

  // ********************************
  // Receiver gain and controller reset
  // ********************************
  // Gain falls back to low on a reset command, like a fresh start.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_gain_high <= 1'b0;
      o_ctrl_reset <= 1'b0;
    end else begin
      o_ctrl_reset <= exec_done && act_reset;
      if (exec_done && act_reset) begin
        o_gain_high <= 1'b0;
      end else if (exec_done && act_gain) begin
        o_gain_high <= gain_val; // Applied before OK goes out
      end
    end
  end

  // ********************************
  // Radio frame hand-off
  // ********************************
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_radio_valid <= 1'b0;
      o_radio_type <= 8'h00;
      o_radio_data <= 32'h0;
      o_radio_id <= 32'h0;
      o_radio_status <= 8'h00;
    end else begin
      o_radio_valid <= exec_done && act_radio;
      if (exec_done && act_radio) begin
        o_radio_type <= f_type;
        o_radio_data <= f_data;
        o_radio_id <= f_id;
        o_radio_status <= rx_buf[10];
      end
    end
  end

  assign o_id_base = base_full;
  assign o_busy = (rx_state == scr_pkg::RX_EXEC);

  // ********************************
  // Reply transmitter
  // ********************************
  scr_reply_tx u_reply_tx (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .rp(rp.snk),
    .o_tx_data(o_tx_data),
    .o_tx_valid(o_tx_valid),
    .i_tx_ready(i_tx_ready)
  );
endmodule : scr_interp
`default_nettype wire

/* File: scr_defines.svh */
/*
 * Constants of the serial command interpreter: frame layout, codes,
 * limits and timing. Assumes a 10 MHz system clock.
 */
// Operation
// - Frames are 14 bytes; checksum is low byte of sum excluding sync, checksum.
// - Host commands carry sequence 0b101, device replies carry sequence 0b100.
// - Host waits for each reply; device replies well within 5 ms.
// - Device owns unique ID plus 128 IDs from a 25-bit programmable base.
// - New base accepted only within lower and upper permitted limits.
// - All-ones identifier is broadcast and never usable as own identifier.
// - Unique identifier cannot be altered; only the base is rewritable.
// - Set-base command: header 0xAB, type 0x18, base MSB first, kept nonvolatile.
// - At most ten successful base rewrites; later attempts get generic failure.
// - Successful rewrite confirmed; out-of-range base answered with type 0x1A.
// - Read-base type 0x58 answered with header 0x8B, type 0x98, base MSB first.
// - Set-gain type 0x08: 0x00 low, 0x01 high; apply then confirm.
// - Read-gain type 0x48 answered with type 0x88, gain in first byte.
// - Reset type 0x0A resets the controller; no reply is sent.
// - Version query answered with type 0x8C, four app then four interface digits.
// - Bad sequence, length, type or checksum gives syntax error naming field.
// - Radio frame with foreign identifier dropped, answered with type 0x22.
// - Completed actions confirmed with reply header and type 0x58.
// - Commands that cannot be carried out get the generic failure reply.
`ifndef SCR_DEFINES_SVH
`define SCR_DEFINES_SVH

`define SCR_SYNC1 8'ha5
`define SCR_SYNC0 8'h5a
`define SCR_FRAME_BYTES 14
`define SCR_BODY_LAST 4'hb
`define SCR_LENGTH 5'h0b
`define SCR_SEQ_CMD 3'h5
`define SCR_SEQ_RADIO 3'h3
`define SCR_REPLY_HDR 8'h8b
`define SCR_ZERO_BYTE 8'h00

`define SCR_T_SET_BASE 8'h18
`define SCR_T_READ_BASE 8'h58
`define SCR_T_SET_GAIN 8'h08
`define SCR_T_READ_GAIN 8'h48
`define SCR_T_RESET 8'h0a
`define SCR_T_READ_VER 8'h4b

`define SCR_R_OK 8'h58
`define SCR_R_FAIL 8'h19
`define SCR_R_BASE 8'h98
`define SCR_R_GAIN 8'h88
`define SCR_R_VER 8'h8c
`define SCR_R_TX_ID 8'h22
`define SCR_R_RANGE 8'h1a

`define SCR_F_SEQ 8'h08
`define SCR_F_LEN 8'h09
`define SCR_F_CHK 8'h0a
`define SCR_F_TYPE 8'h0b

`define SCR_GAIN_LOW 8'h00
`define SCR_GAIN_HIGH 8'h01
`define SCR_BASE_MIN 32'hff80_0000
`define SCR_BASE_MAX 32'hffff_fffe
`define SCR_BROADCAST 32'hffff_ffff
`define SCR_MAX_REWRITES 10

`define SCR_CLOCK_HZ 10000000
`define SCR_REPLY_TIME_US 5000
`define SCR_REPLY_CYCLES (`SCR_REPLY_TIME_US * (`SCR_CLOCK_HZ / 1000000))

`endif

/* File: scr_pkg.sv */
/*
 * Types of the serial command interpreter.
 * Assumes scr_defines.svh for numeric constants.
 */
package scr_pkg;
  // Receive framer states
  typedef enum logic [1:0] {
    RX_SYNC1 = 2'b00,
    RX_SYNC0 = 2'b01,
    RX_BODY = 2'b10,
    RX_EXEC = 2'b11
  } scr_rx_state_t;
endpackage : scr_pkg

/* File: scr_reply_if.sv */
/*
 * Reply request channel between the decoder and the reply transmitter.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface scr_reply_if;
  logic start;
  logic busy;
  logic [7:0] hdr;
  logic [7:0] kind;
  logic [63:0] payload;
  modport src (output start, output hdr, output kind, output payload,
               input busy);
  modport snk (input start, input hdr, input kind, input payload,
               output busy);
endinterface : scr_reply_if
`default_nettype wire

/* File: scr_reply_tx.sv */
/*
 * Reply transmitter: turns one reply request into a 14-byte frame on
 * the outgoing byte stream. Assumes a ready/valid byte sink.
 */
`timescale 1ns/1ps
`default_nettype none
`include "scr_defines.svh"
module scr_reply_tx (
  input wire logic i_clock, // System clock
  input wire logic i_rst, // Async reset, high
  scr_reply_if.snk rp, // Reply request
  output logic [7:0] o_tx_data, // Outgoing byte
  output logic o_tx_valid, // Byte offered
  input wire logic i_tx_ready // Sink takes byte
);
  logic active;
  logic [3:0] idx;
  logic [7:0] hdr;
  logic [7:0] kind;
  logic [63:0] payload;
  logic [7:0] chk;
  logic [7:0] next_chk;

  // ********************************
  // Frame byte selection
  // ********************************
  function automatic logic [7:0] byte_at(input logic [3:0] i);
    logic [7:0] b;
    b = `SCR_ZERO_BYTE;
    case (i)
      4'h0: b = `SCR_SYNC1;
      4'h1: b = `SCR_SYNC0;
      4'h2: b = hdr;
      4'h3: b = kind;
      4'hc: b = `SCR_ZERO_BYTE; // Status, don't-care
      4'hd: b = chk;
      default: b = payload[8'd95 - {i, 3'b000} -: 8];
    endcase
    return b;
  endfunction : byte_at

  // Checksum of header, type, payload and zero status
  always_comb begin
    next_chk = rp.hdr + rp.kind;
    for (int k = 0; k < 8; k++) begin
      next_chk = next_chk + rp.payload[8*k +: 8];
    end
  end

  // Latch the request; it stays stable while the frame goes out
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      hdr <= 8'h00;
      kind <= 8'h00;
      payload <= 64'h0;
      chk <= 8'h00;
    end else if (rp.start && !active) begin
      hdr <= rp.hdr;
      kind <= rp.kind;
      payload <= rp.payload;
      chk <= next_chk;
    end
  end

  // Byte sequencer; the sink may stall on any byte
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      active <= 1'b0;
      idx <= 4'h0;
      o_tx_data <= 8'h00;
    end else if (!active) begin
      if (rp.start) begin
        active <= 1'b1;
        idx <= 4'h0;
        o_tx_data <= `SCR_SYNC1;
      end
    end else if (i_tx_ready) begin
      if (idx == 4'hd) begin
        active <= 1'b0;
      end else begin
        idx <= idx + 4'h1;
        o_tx_data <= byte_at(idx + 4'h1);
      end
    end
  end

  assign o_tx_valid = active;
  assign rp.busy = active;
endmodule : scr_reply_tx
`default_nettype wire

/* File: scr_interp_asserts.sv */
/* Checker of scr_interp: reply framing and event outputs at its ports.
   Assumes one clock domain and an async active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module scr_interp_asserts #(
  parameter logic [31:0] UNIQUE_ID = 32'h0000_0000, // Arbitrary value
  parameter int MAX_REWRITES = 10
) (
  input wire logic i_clock, // Clock
  input wire logic i_rst, // Reset
  input wire logic [7:0] o_tx_data, // Reply byte
  input wire logic o_tx_valid, // Reply byte offered
  input wire logic i_tx_ready, // Reply byte taken
  input wire logic o_busy, // Frame pending
  input wire logic o_nvm_write, // Store pulse
  input wire logic [24:0] o_nvm_base, // Base bits to store
  input wire logic [3:0] o_nvm_count, // Count to store
  input wire logic [31:0] o_id_base, // Range base
  input wire logic o_gain_high, // High gain
  input wire logic o_ctrl_reset, // Reset pulse
  input wire logic o_radio_valid, // Radio frame out
  input wire logic [31:0] o_radio_id // Radio identifier
);
  // ****
  // Position and running sum of the reply
  // ****
  logic [3:0] pos;
  logic [7:0] sum;
  // Cleared between frames so a lost byte shows as a short frame
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pos <= 4'h0;
    end else if (!o_tx_valid) begin
      pos <= 4'h0;
    end else if (i_tx_ready) begin
      pos <= pos + 4'h1;
    end
  end
  // Host's sum of bytes 2..12
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sum <= 8'h00;
    end else if (!o_tx_valid) begin
      sum <= 8'h00;
    end else if (i_tx_ready && pos >= 4'h2 && pos <= 4'hc) begin
      sum <= sum + o_tx_data;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // ****
  // Properties
  // ****
  property p_sync;
    $rose(o_tx_valid) |-> pos == 4'h0 && o_tx_data == 8'ha5;
  endproperty
  a_sync: assert property (p_sync) else $error("bad sync");
  property p_hold;
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data);
  endproperty
  a_hold: assert property (p_hold) else $error("byte lost");
  property p_hdr;
    o_tx_valid && pos == 4'h2 |-> o_tx_data == 8'h8b;
  endproperty
  a_hdr: assert property (p_hdr) else $error("bad header");
  property p_status;
    o_tx_valid && pos == 4'hc |-> o_tx_data == 8'h00;
  endproperty
  a_status: assert property (p_status) else $error("bad status");
  property p_chk;
    o_tx_valid && pos == 4'hd |-> o_tx_data == sum;
  endproperty
  a_chk: assert property (p_chk) else $error("bad checksum");
  property p_len;
    $fell(o_tx_valid) |-> pos == 4'he;
  endproperty
  a_len: assert property (p_len) else $error("bad length");
  property p_busy;
    $rose(o_busy) |-> ##[1:8] !o_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("stuck busy");
  property p_base;
    o_id_base[6:0] == 7'h00;
  endproperty
  a_base: assert property (p_base) else $error("base low bits");
  property p_nvm;
    o_nvm_write |-> o_nvm_base[24:16] == 9'h1ff && o_nvm_count <= MAX_REWRITES;
  endproperty
  a_nvm: assert property (p_nvm) else $error("bad store");
  property p_quiet;
    o_ctrl_reset |=> !o_tx_valid [*8];
  endproperty
  a_quiet: assert property (p_quiet) else $error("reset replied");
  property p_radio;
    o_radio_valid |-> o_radio_id != 32'hffff_ffff && (o_radio_id == 0 ||
      o_radio_id == UNIQUE_ID || o_radio_id[31:7] == o_id_base[31:7]);
  endproperty
  a_radio: assert property (p_radio) else $error("bad id");
  property p_gain;
    $rose(o_gain_high) |-> ##[0:4] $rose(o_tx_valid);
  endproperty
  a_gain: assert property (p_gain) else $error("no confirm");
  c_store: cover property (o_nvm_write);
  c_radio: cover property (o_radio_valid);
  c_reset: cover property (o_ctrl_reset);
endmodule : scr_interp_asserts
bind scr_interp scr_interp_asserts #(
  .UNIQUE_ID(UNIQUE_ID), .MAX_REWRITES(MAX_REWRITES)
) u_chk (
  .i_clock, .i_rst, .o_tx_data, .o_tx_valid, .i_tx_ready, .o_busy,
  .o_nvm_write, .o_nvm_base, .o_nvm_count, .o_id_base, .o_gain_high,
  .o_ctrl_reset, .o_radio_valid, .o_radio_id
);
`default_nettype wire

/* File: scr_host_model.sv */
/* Host model: sends command frames, takes reply bytes.
   Assumes the caller waits for each reply before the next send. */
`timescale 1ns/1ps
`default_nettype none
module scr_host_model (
  input wire logic i_clock, // Clock
  input wire logic i_slow, // Stall reply bytes
  input wire logic [7:0] i_tx_data, // Reply byte
  input wire logic i_tx_valid, // Reply byte offered
  output logic [7:0] o_rx_data, // Command byte
  output logic o_rx_valid, // Command byte strobe
  output logic o_tx_ready // Reply byte taken
);
  // ****
  // Reply capture and command send
  // ****
  logic [0:13][7:0] rep;
  int nbyte = 0, nrep = 0;
  initial begin
    o_rx_data = 8'h00;
    o_rx_valid = 1'b0;
    o_tx_ready = 1'b1;
  end
  // Slow host takes a byte only every other cycle
  always @(negedge i_clock) begin
    o_tx_ready <= !i_slow || !o_tx_ready;
  end
  // Any frame is kept; the caller tells replies apart by type
  always @(posedge i_clock) begin
    if (i_tx_valid && o_tx_ready) begin
      rep[nbyte] = i_tx_data;
      nbyte = (nbyte == 13) ? 0 : nbyte + 1;
      if (nbyte == 0) nrep++;
    end
  end
  // Zero status, sum of bytes 2..12 plus a fault
  task automatic send(input logic [7:0] hdr, input logic [7:0] typ,
      input logic [63:0] cp, input logic [7:0] adj);
    logic [7:0] f [0:13];
    logic [7:0] s;
    for (int i = 0; i < 8; i++) f[4 + i] = cp[63 - 8 * i -: 8];
    f[0] = 8'ha5;
    f[1] = 8'h5a;
    f[2] = hdr;
    f[3] = typ;
    f[12] = 8'h00;
    s = 8'h00;
    for (int i = 2; i < 13; i++) s = s + f[i];
    f[13] = s + adj;
    for (int i = 0; i < 14; i++) begin
      @(negedge i_clock);
      o_rx_data <= f[i];
      o_rx_valid <= 1'b1;
    end
    @(negedge i_clock);
    o_rx_valid <= 1'b0;
    o_rx_data <= ~f[13]; // Idle line must not repeat a stale byte
  endtask : send
endmodule : scr_host_model
`default_nettype wire

/* File: tb_top.sv */
/* Testbench of scr_interp: command table, reset command, mid-run reset.
   Assumes the host model and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ****
  // Setup
  // ****
  localparam logic [31:0] UID = 32'h0246_8ace; // Arbitrary value
  localparam logic [31:0] APPV = 32'h0102_0304; // Arbitrary value
  localparam logic [31:0] IFV = 32'h0506_0708; // Arbitrary value
  localparam logic [24:0] NVB = 25'h1ff_0001; // Stored base bits
  typedef struct packed {
    logic [7:0] hdr, typ;
    logic [63:0] cp;
    logic [7:0] adj, rt;
    logic [63:0] rp;
  } scr_tb_row_t;
  // Count starts at 7: the third rewrite is the tenth
  scr_tb_row_t rows [0:20] = '{
    '{8'hab, 8'h48, 64'h0, 8'h00, 8'h88, 64'h0},
    '{8'hab, 8'h08, 64'h01 << 56, 8'h00, 8'h58, 64'h0},
    '{8'hab, 8'h48, 64'h0, 8'h00, 8'h88, 64'h01 << 56},
    '{8'hab, 8'h08, 64'h02 << 56, 8'h00, 8'h19, 64'h0},
    '{8'hab, 8'h08, 64'h0, 8'h00, 8'h58, 64'h0},
    '{8'hab, 8'h58, 64'h0, 8'h00, 8'h98, {32'hff80_0080, 32'h0}},
    '{8'hab, 8'h18, {32'hff80_0000, 32'h0}, 8'h00, 8'h58, 64'h0},
    '{8'hab, 8'h18, {32'hff7f_ff80, 32'h0}, 8'h00, 8'h1a, 64'h0},
    '{8'hab, 8'h18, {32'hffff_fffe, 32'h0}, 8'h00, 8'h58, 64'h0},
    '{8'hab, 8'h58, 64'h0, 8'h00, 8'h98, {32'hffff_ff80, 32'h0}},
    '{8'hab, 8'h18, {32'hffff_fff0, 32'h0}, 8'h00, 8'h58, 64'h0},
    '{8'hab, 8'h18, {32'hff80_0000, 32'h0}, 8'h00, 8'h19, 64'h0},
    '{8'hab, 8'h4b, 64'h0, 8'h00, 8'h8c, {APPV, IFV}},
    '{8'h6b, 8'hf6, 64'hffff_ff85, 8'h00, 8'h58, 64'h0},
    '{8'h6b, 8'hf6, {32'h0, UID}, 8'h00, 8'h58, 64'h0},
    '{8'h6b, 8'hf6, 64'hffff_ffff, 8'h00, 8'h22, 64'h0},
    '{8'h6b, 8'hf6, 64'h1234_5600, 8'h00, 8'h22, 64'h0},
    '{8'hab, 8'h77, 64'h0, 8'h00, 8'h0b, 64'h0},
    '{8'hcb, 8'h48, 64'h0, 8'h00, 8'h08, 64'h0},
    '{8'hac, 8'h48, 64'h0, 8'h00, 8'h09, 64'h0},
    '{8'hab, 8'h48, 64'h0, 8'h01, 8'h0a, 64'h0}
  };
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic slow = 1'b0;
  logic [24:0] i_nvm_base = NVB;
  logic [3:0] i_nvm_count = 4'h7;
  logic [7:0] i_rx_data, o_tx_data;
  logic i_rx_valid, o_tx_valid, i_tx_ready, o_nvm_write, o_gain_high;
  logic o_ctrl_reset, o_radio_valid, o_busy;
  logic [24:0] o_nvm_base;
  logic [3:0] o_nvm_count;
  logic [31:0] o_id_base, o_radio_id;
  int n_radio = 0, n_crst = 0, n_nvm = 0;
  int fail_count = 0, check_count = 0;
  always #50 i_clock = ~i_clock;
  scr_interp #(.UNIQUE_ID(UID), .APP_VERSION(APPV), .IF_VERSION(IFV),
    .REPLY_LIMIT(32)) uut (.i_clock, .i_rst, .i_rx_data, .i_rx_valid,
    .o_tx_data, .o_tx_valid, .i_tx_ready, .i_nvm_base, .i_nvm_count,
    .o_nvm_write, .o_nvm_base, .o_nvm_count, .o_id_base, .o_gain_high,
    .o_ctrl_reset, .o_radio_valid, .o_radio_type(), .o_radio_data(),
    .o_radio_id, .o_radio_status(), .o_busy);
  scr_host_model host (.i_clock, .i_slow(slow), .i_tx_data(o_tx_data),
    .i_tx_valid(o_tx_valid), .o_rx_data(i_rx_data),
    .o_rx_valid(i_rx_valid), .o_tx_ready(i_tx_ready));
  // Pulses are counted, not sampled once
  always @(posedge i_clock) begin
    if (o_radio_valid === 1'b1) n_radio++;
    if (o_ctrl_reset === 1'b1) n_crst++;
    if (o_nvm_write === 1'b1) n_nvm++;
  end
  // ****
  // Tasks
  // ****
  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    $display("checks=%0d failures=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results
  // Bound of 200 cycles, over six times the reply limit of 32
  task automatic reply(input logic [7:0] rt, input logic [63:0] rp);
    int n0;
    logic [7:0] s;
    n0 = host.nrep;
    for (int i = 0; i < 200 && host.nrep == n0; i++) @(negedge i_clock);
    if (host.nrep == n0) begin
      fail_count++;
      results();
    end
    s = 8'h00;
    for (int i = 2; i < 13; i++) s = s + host.rep[i];
    chk(host.rep[0:3], {24'ha55a8b, rt});
    chk(host.rep[4:7], rp[63:32]);
    chk(host.rep[8:11], rp[31:0]);
    chk(host.rep[12:13], {8'h00, s});
  endtask : reply
  // ****
  // Sequence
  // ****
  initial begin
    int n0;
    repeat (5) @(negedge i_clock);
    i_rst = 1'b0;
    repeat (2) @(negedge i_clock);
    foreach (rows[r]) begin
      slow = r[0];
      host.send(rows[r].hdr, rows[r].typ, rows[r].cp, rows[r].adj);
      reply(rows[r].rt, rows[r].rp);
    end
    chk(n_radio, 2);
    chk(n_nvm, 3);
    chk(o_id_base, 32'hffff_ff80);
    chk({o_nvm_base, o_nvm_count}, {25'h1ff_ffff, 4'ha});
    host.send(8'hab, 8'h08, 64'h01 << 56, 8'h00);
    reply(8'h58, 64'h0);
    n0 = host.nrep;
    host.send(8'hab, 8'h0a, 64'h0, 8'h00);
    repeat (40) @(negedge i_clock);
    chk(n_crst, 1);
    chk(host.nrep - n0, 0);
    chk(o_gain_high, 32'h0);
    i_rst = 1'b1;
    @(negedge i_clock);
    chk({o_id_base[31:1], o_tx_valid}, 32'h0);
    i_rst = 1'b0;
    repeat (2) @(negedge i_clock);
    chk(o_id_base, {NVB, 7'h00});
    host.send(8'hab, 8'h58, 64'h0, 8'h00);
    reply(8'h98, {NVB, 39'h0});
    results();
  end
endmodule : tb_top
`default_nettype wire
